// *** rtl/dsau_defines.svh ***
// constants for the data space access unit
// Contract
// - upper data half maps onto program page
// - visibility needs address top bit and enable
// - program address is page plus low fifteen bits
// - only low program word returned as data
// - visibility suspended during table operations
// - outside repeat add one or two cycles
// - repeat edges add two, middle iterations none
// - multiply class reads split X and Y pointers
// - other instructions see one linear space
// - all writes use the X write path
// - modulo everywhere, bit reverse on X writes
// - X/Y boundary fixed in hardware
// - invalid reads return zero
// - sixteen bit byte addresses, two lanes
// - byte reads select lane onto low byte
// - byte writes strobe only matching lane
// - post increment one for byte, two word
// - misaligned word raises address error trap
`ifndef DSAU_DEFINES_SVH
`define DSAU_DEFINES_SVH

`define DSAU_X_BASE 16'h0800
`define DSAU_X_END 16'h08ff
`define DSAU_Y_BASE 16'h0900
`define DSAU_Y_END 16'h09ff
`define DSAU_PTR_XA 4'h8
`define DSAU_PTR_XB 4'h9
`define DSAU_PTR_YA 4'ha
`define DSAU_PTR_YB 4'hb
`define DSAU_STEP_BYTE 16'h0001
`define DSAU_STEP_WORD 16'h0002
`define DSAU_EXTRA_NONE 2'h0
`define DSAU_EXTRA_ONE 2'h1
`define DSAU_EXTRA_TWO 2'h2
`define DSAU_LANE_LO 2'h1
`define DSAU_LANE_HI 2'h2
`define DSAU_LANE_BOTH 2'h3
`define DSAU_LANE_NONE 2'h0
`define DSAU_REG_CTRL 4'h0
`define DSAU_REG_PAGE 4'h1
`define DSAU_REG_STATUS 4'h2
`define DSAU_REG_MASK 4'h3
`define DSAU_CTRL_PVE 0
`define DSAU_ST_RD_TRAP 0
`define DSAU_ST_WR_TRAP 1
`define DSAU_ST_ZERO 2
`define DSAU_ST_W 3
`define DSAU_CTRL_RST 1'h0
`define DSAU_PAGE_RST 8'h00
`define DSAU_ST_RST 3'h0
`define DSAU_ZERO16 16'h0000

`endif

// *** rtl/dsau_pkg.sv ***
// types for the data space access unit
package dsau_pkg;

   typedef enum logic [1:0] {
      KIND_MOV = 2'b00,
      KIND_MOVD = 2'b01,
      KIND_MAC_PREFETCH = 2'b10,
      KIND_OTHER = 2'b11
   } instr_kind_t;

   typedef enum logic [1:0] {
      SRC_ZERO = 2'b00,
      SRC_RAM = 2'b01,
      SRC_PM = 2'b10
   } x_src_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT_A = 2'b01,
      ST_WAIT_B = 2'b11
   } stall_state_t;

endpackage

// *** rtl/data_space_access_unit.sv ***
// data space decode, visibility mapping and access logic
`timescale 1ns/100ps
`include "dsau_defines.svh"
module data_space_access_unit
   import dsau_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [15:0] reg_rdata_o,
   input wire logic x_req_i,
   input wire logic x_wr_i,
   input wire logic x_byte_i,
   input wire logic x_mac_i,
   input wire logic [3:0] x_ptr_sel_i,
   input wire logic [15:0] x_ea_i,
   input wire logic [15:0] x_wdata_i,
   input wire logic y_req_i,
   input wire logic [3:0] y_ptr_sel_i,
   input wire logic [15:0] y_ea_i,
   input wire instr_kind_t instr_kind_i,
   input wire logic table_busy_i,
   input wire logic rep_active_i,
   input wire logic rep_first_i,
   input wire logic rep_last_i,
   input wire logic rep_irq_exit_i,
   input wire logic rep_irq_reentry_i,
   input wire logic [15:0] ptr_i,
   input wire logic mod_en_i,
   input wire logic [15:0] mod_start_i,
   input wire logic [15:0] mod_end_i,
   input wire logic brev_en_i,
   input wire logic [15:0] brev_mod_i,
   output logic ready_o,
   output logic [15:0] x_rdata_o,
   output logic x_valid_o,
   output logic [15:0] y_rdata_o,
   output logic y_valid_o,
   output logic [15:0] ptr_next_o,
   output logic addr_trap_o,
   output logic irq_o,
   output logic [15:0] ram_x_addr_o,
   output logic ram_x_re_o,
   output logic [1:0] ram_x_we_o,
   output logic [15:0] ram_x_wdata_o,
   input wire logic [15:0] ram_x_rdata_i,
   output logic [15:0] ram_y_addr_o,
   output logic ram_y_re_o,
   input wire logic [15:0] ram_y_rdata_i,
   output logic [23:0] pm_addr_o,
   output logic pm_re_o,
   input wire logic [23:0] pm_rdata_i
);

   // region decode, boundary is constant
   function automatic logic in_x(input logic [15:0] ea);
      in_x = (ea >= `DSAU_X_BASE) && (ea <= `DSAU_X_END);
   endfunction

   function automatic logic in_y(input logic [15:0] ea);
      in_y = (ea >= `DSAU_Y_BASE) && (ea <= `DSAU_Y_END);
   endfunction

   function automatic logic [15:0] rev16(input logic [15:0] v);
      logic [15:0] r;
      r = `DSAU_ZERO16;
      for (int i = 0; i < 16; i++) begin
         r[i] = v[15 - i];
      end
      rev16 = r;
   endfunction

   function automatic logic [1:0] psv_extra(input instr_kind_t k, input logic rep, input logic edge_it);
      logic [1:0] e;
      e = `DSAU_EXTRA_TWO;
      if (rep) begin
         e = edge_it ? `DSAU_EXTRA_TWO : `DSAU_EXTRA_NONE;
      end else if (k != KIND_OTHER) begin
         e = `DSAU_EXTRA_ONE;
      end
      psv_extra = e;
   endfunction

   // reset release
   logic rst_meta_q;
   logic rst_sync_q;
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   wire rst_n = rst_sync_q;

   // registers
   logic pve_q, pve_d;
   logic [7:0] page_q, page_d;
   logic [`DSAU_ST_W-1:0] status_q, status_d;
   logic [`DSAU_ST_W-1:0] mask_q, mask_d;
   logic [15:0] rdata_q, rdata_d;
   logic [`DSAU_ST_W-1:0] events;

   // datapath state
   stall_state_t state_q, state_d;
   x_src_t s1_src_q, s1_src_d;
   logic s1_xv_q, s1_xv_d;
   logic s1_byte_q, s1_byte_d;
   logic s1_hi_q, s1_hi_d;
   logic s1_yv_q, s1_yv_d;
   logic s1_yok_q, s1_yok_d;
   logic [15:0] xr_q, xr_d;
   logic xv_q, xv_d;
   logic [15:0] yr_q, yr_d;
   logic yv_q, yv_d;
   logic [15:0] ptr_q, ptr_d;
   logic trap_q, trap_d;

   // request decode
   logic accept;
   logic x_mis;
   logic y_mis;
   logic psv_hit;
   logic x_mac_ok;
   logic y_ok;
   logic x_ram_ok;
   logic [15:0] x_word;
   logic [15:0] step;
   logic [15:0] x_sel;
   logic [1:0] extra;

   always_comb begin
      accept = (x_req_i || y_req_i) && (state_q == ST_IDLE);
      x_mis = x_req_i && !x_byte_i && x_ea_i[0];
      y_mis = y_req_i && y_ea_i[0];
      x_word = {x_ea_i[15:1], 1'b0};
      // visibility needs top address bit, enable and no table op
      psv_hit = x_ea_i[15] && pve_q && !table_busy_i;
      // multiply class reads keep X pointers in X and Y pointers in Y
      x_mac_ok = in_x(x_ea_i) && ((x_ptr_sel_i == `DSAU_PTR_XA) || (x_ptr_sel_i == `DSAU_PTR_XB));
      y_ok = x_mac_i && in_y(y_ea_i)
         && ((y_ptr_sel_i == `DSAU_PTR_YA) || (y_ptr_sel_i == `DSAU_PTR_YB));
      // any other access sees X and Y as one space
      x_ram_ok = (x_mac_i && !x_wr_i) ? x_mac_ok : (in_x(x_ea_i) || in_y(x_ea_i));
      step = x_byte_i ? `DSAU_STEP_BYTE : `DSAU_STEP_WORD;
      extra = psv_extra(instr_kind_i, rep_active_i,
         rep_first_i || rep_last_i || rep_irq_exit_i || rep_irq_reentry_i);
   end

   // memory ports
   always_comb begin
      ram_x_addr_o = x_word;
      ram_x_re_o = accept && x_req_i && !x_wr_i && x_ram_ok && !x_ea_i[15];
      ram_x_wdata_o = x_wdata_i;
      ram_x_we_o = `DSAU_LANE_NONE;
      // writes only over X, never for a misaligned word
      if (accept && x_req_i && x_wr_i && x_ram_ok && !x_mis) begin
         if (x_byte_i) begin
            ram_x_we_o = x_ea_i[0] ? `DSAU_LANE_HI : `DSAU_LANE_LO;
         end else begin
            ram_x_we_o = `DSAU_LANE_BOTH;
         end
      end
      ram_y_addr_o = {y_ea_i[15:1], 1'b0};
      ram_y_re_o = accept && y_req_i && y_ok;
      // page above, low fifteen address bits straight through
      pm_addr_o = {1'b0, page_q, x_ea_i[14:0]};
      pm_re_o = accept && x_req_i && !x_wr_i && psv_hit;
   end

   // stall after a visibility read
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (pm_re_o) begin
               state_d = (extra == `DSAU_EXTRA_TWO) ? ST_WAIT_A
                  : (extra == `DSAU_EXTRA_ONE) ? ST_WAIT_B : ST_IDLE;
            end
         end
         ST_WAIT_A: begin
            state_d = ST_WAIT_B;
         end
         ST_WAIT_B: begin
            state_d = ST_IDLE;
         end
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // stage one, what the answer is made of
   always_comb begin
      s1_src_d = SRC_ZERO;
      s1_xv_d = 1'b0;
      s1_byte_d = 1'b0;
      s1_hi_d = 1'b0;
      s1_yv_d = 1'b0;
      s1_yok_d = 1'b0;
      if (accept) begin
         s1_xv_d = x_req_i && !x_wr_i;
         s1_byte_d = x_byte_i;
         s1_hi_d = x_ea_i[0];
         s1_yv_d = y_req_i;
         s1_yok_d = y_ok;
         if (x_ea_i[15]) begin
            s1_src_d = psv_hit ? SRC_PM : SRC_ZERO;
         end else begin
            s1_src_d = x_ram_ok ? SRC_RAM : SRC_ZERO;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         s1_src_q <= SRC_ZERO;
         s1_xv_q <= 1'b0;
         s1_byte_q <= 1'b0;
         s1_hi_q <= 1'b0;
         s1_yv_q <= 1'b0;
         s1_yok_q <= 1'b0;
      end else begin
         s1_src_q <= s1_src_d;
         s1_xv_q <= s1_xv_d;
         s1_byte_q <= s1_byte_d;
         s1_hi_q <= s1_hi_d;
         s1_yv_q <= s1_yv_d;
         s1_yok_q <= s1_yok_d;
      end
   end

   // pointer post-modify, bit reverse only on X writes
   always_comb begin
      ptr_d = ptr_q;
      if (accept) begin
         if (brev_en_i && x_req_i && x_wr_i && in_x(x_ea_i)) begin
            ptr_d = rev16(rev16(ptr_i) + rev16(brev_mod_i));
         end else if (mod_en_i && ((ptr_i + step - `DSAU_STEP_BYTE) == mod_end_i)) begin
            ptr_d = mod_start_i;
         end else begin
            ptr_d = ptr_i + step;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         ptr_q <= `DSAU_ZERO16;
      end else begin
         ptr_q <= ptr_d;
      end
   end

   // misaligned words trap, invalid reads logged
   always_comb begin
      trap_d = 1'b0;
      events = `DSAU_ST_RST;
      if (accept) begin
         trap_d = x_mis || y_mis;
         events[`DSAU_ST_RD_TRAP] = (x_mis && !x_wr_i) || y_mis;
         events[`DSAU_ST_WR_TRAP] = x_mis && x_wr_i;
         events[`DSAU_ST_ZERO] = (x_req_i && !x_wr_i && (x_ea_i[15] ? !psv_hit : !x_ram_ok))
            || (y_req_i && !y_ok);
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         trap_q <= 1'b0;
      end else begin
         trap_q <= trap_d;
      end
   end

   // answer path, one cycle after stage one
   always_comb begin
      x_sel = `DSAU_ZERO16;
      unique case (s1_src_q)
         SRC_RAM: x_sel = ram_x_rdata_i;
         SRC_PM: x_sel = pm_rdata_i[15:0];
         default: x_sel = `DSAU_ZERO16;
      endcase
      // byte read takes the addressed lane into the low byte
      if (s1_byte_q) begin
         x_sel = {8'h00, s1_hi_q ? x_sel[15:8] : x_sel[7:0]};
      end
      xr_d = s1_xv_q ? x_sel : xr_q;
      xv_d = s1_xv_q;
      // Y carries whole words only
      yr_d = s1_yv_q ? (s1_yok_q ? ram_y_rdata_i : `DSAU_ZERO16) : yr_q;
      yv_d = s1_yv_q;
   end

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         xr_q <= `DSAU_ZERO16;
         xv_q <= 1'b0;
         yr_q <= `DSAU_ZERO16;
         yv_q <= 1'b0;
      end else begin
         xr_q <= xr_d;
         xv_q <= xv_d;
         yr_q <= yr_d;
         yv_q <= yv_d;
      end
   end

   // register file
   always_comb begin
      pve_d = pve_q;
      page_d = page_q;
      mask_d = mask_q;
      rdata_d = `DSAU_ZERO16;
      status_d = status_q;
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            `DSAU_REG_CTRL: pve_d = reg_wdata_i[`DSAU_CTRL_PVE];
            `DSAU_REG_PAGE: page_d = reg_wdata_i[7:0];
            `DSAU_REG_MASK: mask_d = reg_wdata_i[`DSAU_ST_W-1:0];
            default: ;
         endcase
      end
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            `DSAU_REG_CTRL: rdata_d = {15'h0000, pve_q};
            `DSAU_REG_PAGE: rdata_d = {8'h00, page_q};
            `DSAU_REG_STATUS: begin
               rdata_d = {13'h0000, status_q};
               status_d = `DSAU_ST_RST;
            end
            `DSAU_REG_MASK: rdata_d = {13'h0000, mask_q};
            default: rdata_d = `DSAU_ZERO16;
         endcase
      end
      // new events win over the read clear
      status_d = status_d | events;
   end

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         pve_q <= `DSAU_CTRL_RST;
         page_q <= `DSAU_PAGE_RST;
         status_q <= `DSAU_ST_RST;
         mask_q <= `DSAU_ST_RST;
         rdata_q <= `DSAU_ZERO16;
      end else begin
         pve_q <= pve_d;
         page_q <= page_d;
         status_q <= status_d;
         mask_q <= mask_d;
         rdata_q <= rdata_d;
      end
   end

   // outputs
   always_comb begin
      ready_o = (state_q == ST_IDLE) && rst_n;
      x_rdata_o = xr_q;
      x_valid_o = xv_q;
      y_rdata_o = yr_q;
      y_valid_o = yv_q;
      ptr_next_o = ptr_q;
      addr_trap_o = trap_q;
      reg_rdata_o = rdata_q;
      irq_o = |(status_q & mask_q);
   end

endmodule

// *** sim/far_mem_model.sv ***
// memory side model answering ram and program reads
`timescale 1ns/100ps
module far_mem_model (
   input wire logic clk_sys_i,
   input wire logic [15:0] x_addr_i,
   input wire logic x_re_i,
   output logic [15:0] x_data_o = 16'h0000,
   input wire logic [15:0] y_addr_i,
   input wire logic y_re_i,
   output logic [15:0] y_data_o = 16'h0000,
   input wire logic [23:0] pm_addr_i,
   input wire logic pm_re_i,
   output logic [23:0] pm_data_o = 24'h000000
);
   // idle cycles invert the lines so stale data never looks valid
   always_ff @(posedge clk_sys_i) begin
      x_data_o <= x_re_i ? x_addr_i ^ 16'ha500 : ~x_data_o;
      y_data_o <= y_re_i ? y_addr_i ^ 16'h5a00 : ~y_data_o;
      pm_data_o <= pm_re_i ? {8'ha5, pm_addr_i[22:15], pm_addr_i[7:0]} : ~pm_data_o;
   end
endmodule

// *** sim/dsau_checker.sv ***
// assertions on the data space access unit ports
`timescale 1ns/100ps
module dsau_checker
   import dsau_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic x_req_i,
   input wire logic x_wr_i,
   input wire logic x_byte_i,
   input wire logic [15:0] x_ea_i,
   input wire instr_kind_t instr_kind_i,
   input wire logic table_busy_i,
   input wire logic rep_active_i,
   input wire logic rep_first_i,
   input wire logic rep_last_i,
   input wire logic rep_irq_exit_i,
   input wire logic rep_irq_reentry_i,
   input wire logic [15:0] ptr_i,
   input wire logic mod_en_i,
   input wire logic brev_en_i,
   input wire logic ready_o,
   input wire logic [15:0] ptr_next_o,
   input wire logic addr_trap_o,
   input wire logic [1:0] ram_x_we_o,
   input wire logic [23:0] pm_addr_o,
   input wire logic pm_re_o
);
   logic tk;
   logic pv;
   logic edg;
   assign tk = x_req_i && ready_o;
   assign pv = tk && pm_re_o && !x_wr_i;
   assign edg = rep_first_i || rep_last_i || rep_irq_exit_i || rep_irq_reentry_i;
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_b_i);
   a_stall_other:
   assert property (pv && !rep_active_i && instr_kind_i == KIND_OTHER |=> !ready_o [*2] ##1 ready_o)
      else $error("two cycle stall wrong");
   a_stall_short:
   assert property (pv && !rep_active_i && instr_kind_i != KIND_OTHER |=> !ready_o ##1 ready_o)
      else $error("one cycle stall wrong");
   a_rep_edge_stall:
   assert property (pv && rep_active_i && edg |=> !ready_o [*2] ##1 ready_o)
      else $error("repeat edge stall wrong");
   a_rep_mid_fast:
   assert property (pv && rep_active_i && !edg |=> ready_o)
      else $error("repeat middle stalled");
   a_pm_addr_low:
   assert property (pm_re_o |-> pm_addr_o[14:0] == x_ea_i[14:0] && !pm_addr_o[23])
      else $error("program address wrong");
   a_pm_gate:
   assert property (pm_re_o |-> x_ea_i[15] && !table_busy_i)
      else $error("program read not allowed");
   a_byte_lane:
   assert property (tk && x_wr_i && x_byte_i && x_ea_i inside {[16'h0800:16'h09ff]}
      |-> ram_x_we_o == {x_ea_i[0], !x_ea_i[0]})
      else $error("byte lane strobe wrong");
   a_misalign_trap:
   assert property (tk && !x_byte_i && x_ea_i[0] |=> addr_trap_o)
      else $error("missing address trap");
   a_word_no_write:
   assert property (tk && x_wr_i && !x_byte_i && x_ea_i[0] |-> ram_x_we_o == 2'b00)
      else $error("misaligned write strobed");
   a_ptr_step:
   assert property (tk && !mod_en_i && !brev_en_i
      |=> ptr_next_o == $past(ptr_i) + ($past(x_byte_i) ? 16'h0001 : 16'h0002))
      else $error("post increment wrong");
   a_high_no_write:
   assert property (tk && x_wr_i && x_ea_i[15] |-> ram_x_we_o == 2'b00)
      else $error("write strobed above data memory");
endmodule
bind data_space_access_unit dsau_checker u_chk (.clk_sys_i, .rst_b_i, .x_req_i, .x_wr_i, .x_byte_i,
   .x_ea_i, .instr_kind_i, .table_busy_i, .rep_active_i, .rep_first_i, .rep_last_i, .rep_irq_exit_i,
   .rep_irq_reentry_i, .ptr_i, .mod_en_i, .brev_en_i, .ready_o, .ptr_next_o, .addr_trap_o,
   .ram_x_we_o, .pm_addr_o, .pm_re_o);

// *** sim/data_space_access_unit_tb.sv ***
// self-checking bench for the data space access unit
`timescale 1ns/100ps
module data_space_access_unit_tb;
   import dsau_pkg::*;
   logic clk_sys_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [3:0] rg_a = 4'h0;
   logic [15:0] rg_d = 16'h0000;
   logic rg_w = 1'b0;
   logic rg_r = 1'b0;
   logic x_req = 1'b0;
   logic y_req = 1'b0;
   logic x_wr = 1'b0;
   logic x_byte = 1'b0;
   logic x_mac = 1'b0;
   logic [3:0] sel = 4'h0;
   logic [15:0] ea = 16'h0000;
   instr_kind_t kind = KIND_MOV;
   logic tbusy = 1'b0;
   logic [4:0] rep = 5'h00;
   logic mod_en = 1'b0;
   logic brev_en = 1'b0;
   logic [15:0] mlim = 16'h0000;
   logic [15:0] rg_q, x_rd, y_rd, ptr_nx, rxa, rxd, rya, ryd;
   logic rdy, x_vld, y_vld, trap, irq, rxre, ryre, pmre;
   logic [1:0] rxwe;
   logic [23:0] pma, pmd;
   int error_cnt = 0;
   int n_compared = 0;
   always #5 clk_sys_i = ~clk_sys_i;
   data_space_access_unit dut (.clk_sys_i, .rst_b_i, .reg_addr_i(rg_a), .reg_wdata_i(rg_d),
      .reg_wr_i(rg_w), .reg_rd_i(rg_r), .reg_rdata_o(rg_q), .x_req_i(x_req), .x_wr_i(x_wr),
      .x_byte_i(x_byte), .x_mac_i(x_mac), .x_ptr_sel_i(sel), .x_ea_i(ea), .x_wdata_i(~ea),
      .y_req_i(y_req), .y_ptr_sel_i(sel), .y_ea_i(ea), .instr_kind_i(kind), .table_busy_i(tbusy),
      .rep_active_i(rep[4]), .rep_first_i(rep[3]), .rep_last_i(rep[2]), .rep_irq_exit_i(rep[1]),
      .rep_irq_reentry_i(rep[0]), .ptr_i(ea), .mod_en_i(mod_en), .mod_start_i({mlim[15:8], 8'h00}),
      .mod_end_i(mlim), .brev_en_i(brev_en), .brev_mod_i(mlim), .ready_o(rdy),
      .x_rdata_o(x_rd), .x_valid_o(x_vld), .y_rdata_o(y_rd), .y_valid_o(y_vld), .ptr_next_o(ptr_nx),
      .addr_trap_o(trap), .irq_o(irq), .ram_x_addr_o(rxa), .ram_x_re_o(rxre), .ram_x_we_o(rxwe),
      .ram_x_wdata_o(), .ram_x_rdata_i(rxd), .ram_y_addr_o(rya), .ram_y_re_o(ryre),
      .ram_y_rdata_i(ryd), .pm_addr_o(pma), .pm_re_o(pmre), .pm_rdata_i(pmd));
   far_mem_model mem (.clk_sys_i, .x_addr_i(rxa), .x_re_i(rxre), .x_data_o(rxd), .y_addr_i(rya),
      .y_re_i(ryre), .y_data_o(ryd), .pm_addr_i(pma), .pm_re_i(pmre), .pm_data_o(pmd));
   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wreg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys_i);
      rg_a <= a;
      rg_d <= d;
      rg_w <= 1'b1;
      @(posedge clk_sys_i);
      rg_w <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk_sys_i);
      rg_a <= a;
      rg_r <= 1'b1;
      @(posedge clk_sys_i);
      rg_r <= 1'b0;
      #1;
      chk("register read", e, rg_q);
   endtask
   task automatic acc(input logic xr, yr, wr, by, input logic [3:0] s, input logic [15:0] e);
      int n;
      @(posedge clk_sys_i);
      x_req <= xr;
      y_req <= yr;
      x_wr <= wr;
      x_byte <= by;
      sel <= s;
      ea <= e;
      #1;
      n = 0;
      while (rdy !== 1'b1 && n < 20) begin
         @(posedge clk_sys_i);
         #1;
         n++;
      end
      @(posedge clk_sys_i);
      x_req <= 1'b0;
      y_req <= 1'b0;
      if (n >= 20) begin
         error_cnt++;
         tally_and_finish;
      end
   endtask
   task automatic rx(input logic yp, input logic [15:0] e);
      @(posedge clk_sys_i);
      #1;
      chk("read valid", 16'h0001, {15'h0, yp ? y_vld : x_vld});
      chk("read data", e, yp ? y_rd : x_rd);
   endtask
   task automatic stall(input instr_kind_t k, input logic [4:0] r, input logic [15:0] e);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      kind <= k;
      rep <= r;
      acc(1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 16'h8006);
      #1;
      while (rdy !== 1'b1 && n < 4) begin
         @(posedge clk_sys_i);
         #1;
         n++;
      end
      chk("stall cycles", e, 16'(n));
   endtask
   task automatic t_reset;
      for (int i = 0; i < 5; i++) rreg(i < 4 ? 4'(i) : 4'h7, 16'h0000);
   endtask
   task automatic t_vis;
      wreg(4'h0, 16'h0001);
      wreg(4'h1, 16'h003c);
      acc(1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 16'h8006);
      rx(1'b0, 16'h3c06);
      @(posedge clk_sys_i);
      tbusy <= 1'b1;
      acc(1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 16'h8006);
      rx(1'b0, 16'h0000);
      @(posedge clk_sys_i);
      tbusy <= 1'b0;
      wreg(4'h0, 16'h0000);
      acc(1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 16'h8006);
      rx(1'b0, 16'h0000);
   endtask
   task automatic t_stall;
      wreg(4'h0, 16'h0001);
      stall(KIND_OTHER, 5'b11000, 16'h2);
      stall(KIND_MOV, 5'b10100, 16'h2);
      stall(KIND_OTHER, 5'b10010, 16'h2);
      stall(KIND_MOVD, 5'b10001, 16'h2);
      stall(KIND_OTHER, 5'b10000, 16'h0);
      stall(KIND_MOV, 5'b00000, 16'h1);
      stall(KIND_MOVD, 5'b00000, 16'h1);
      stall(KIND_MAC_PREFETCH, 5'b00000, 16'h1);
      stall(KIND_OTHER, 5'b00000, 16'h2);
      wreg(4'h0, 16'h0000);
   endtask
   task automatic t_lin;
      acc(1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 16'h0900);
      rx(1'b0, 16'hac00);
      acc(1'b1, 1'b0, 1'b0, 1'b1, 4'h0, 16'h0803);
      rx(1'b0, 16'h00ad);
      acc(1'b1, 1'b0, 1'b0, 1'b1, 4'h0, 16'h0802);
      rx(1'b0, 16'h0002);
      acc(1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 16'h0200);
      rx(1'b0, 16'h0000);
      acc(1'b1, 1'b0, 1'b1, 1'b1, 4'h0, 16'h0805);
      #1;
      chk("pointer byte step", 16'h0806, ptr_nx);
      acc(1'b1, 1'b0, 1'b1, 1'b0, 4'h0, 16'h0810);
      #1;
      chk("pointer word step", 16'h0812, ptr_nx);
      acc(1'b1, 1'b0, 1'b1, 1'b0, 4'h0, 16'h8004);
   endtask
   task automatic t_mod;
      @(posedge clk_sys_i);
      mod_en <= 1'b1;
      mlim <= 16'h0811;
      acc(1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 16'h0810);
      #1;
      chk("modulo x wrap", 16'h0800, ptr_nx);
      @(posedge clk_sys_i);
      mlim <= 16'h0911;
      acc(1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 16'h0910);
      #1;
      chk("modulo y wrap", 16'h0900, ptr_nx);
      @(posedge clk_sys_i);
      mod_en <= 1'b0;
      brev_en <= 1'b1;
      mlim <= 16'h0008;
      acc(1'b1, 1'b0, 1'b1, 1'b0, 4'h0, 16'h0800);
      #1;
      chk("reversed step", 16'h0808, ptr_nx);
      acc(1'b1, 1'b0, 1'b1, 1'b0, 4'h0, 16'h0808);
      #1;
      chk("reversed carry", 16'h0804, ptr_nx);
      acc(1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 16'h0808);
      #1;
      chk("read skips reverse", 16'h080a, ptr_nx);
      @(posedge clk_sys_i);
      brev_en <= 1'b0;
   endtask
   task automatic t_mac;
      @(posedge clk_sys_i);
      x_mac <= 1'b1;
      acc(1'b1, 1'b0, 1'b0, 1'b0, 4'h8, 16'h0810);
      rx(1'b0, 16'had10);
      acc(1'b1, 1'b0, 1'b0, 1'b0, 4'h9, 16'h0904);
      rx(1'b0, 16'h0000);
      acc(1'b1, 1'b0, 1'b0, 1'b0, 4'ha, 16'h0810);
      rx(1'b0, 16'h0000);
      acc(1'b0, 1'b1, 1'b0, 1'b0, 4'hb, 16'h0904);
      rx(1'b1, 16'h5304);
      acc(1'b0, 1'b1, 1'b0, 1'b0, 4'h8, 16'h0904);
      rx(1'b1, 16'h0000);
      @(posedge clk_sys_i);
      x_mac <= 1'b0;
   endtask
   task automatic t_trap;
      wreg(4'h3, 16'h0002);
      rreg(4'h2, 16'h0004);
      acc(1'b1, 1'b0, 1'b1, 1'b0, 4'h0, 16'h0803);
      #1;
      chk("trap pulse", 16'h0001, {15'h0, trap});
      @(posedge clk_sys_i);
      #1;
      chk("irq raised", 16'h0001, {15'h0, irq});
      rreg(4'h2, 16'h0002);
      chk("irq cleared", 16'h0000, {15'h0, irq});
      acc(1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 16'h0805);
      rx(1'b0, 16'had04);
      chk("irq masked", 16'h0000, {15'h0, irq});
      acc(1'b0, 1'b1, 1'b0, 1'b0, 4'hb, 16'h0905);
      #1;
      chk("y trap pulse", 16'h0001, {15'h0, trap});
      rreg(4'h2, 16'h0005);
   endtask
   initial begin
      repeat (8) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      t_reset;
      t_vis;
      t_stall;
      t_lin;
      t_mod;
      t_mac;
      t_trap;
      tally_and_finish;
   end
endmodule
